// [hdl/i2c_engine_pkg.sv]
// constants, types and behaviour summary for the two-wire bus engine
//
// Behaviour
// - start is SDA falling while SCL high, from idle, before every transfer
// - stop is SDA rising while SCL high, ending every transfer
// - repeated start after a wait lets the master turn the bus round
// - SDA stable while SCL high; changes there are start or stop only
// - one bit per SCL pulse, sampled high, changed only while SCL low
// - receiver pulls SDA low on ninth clock to ack, releases to nack
// - anyone may hold SCL low; master waits until SCL is seen high
// - bus idle with both lines high between stop and next start
// - master starts a transfer only when the bus is not busy
// - first byte is address plus direction; zero means master transmits
// - after repeated start the same address is resent with direction one
// - master generates a ninth clock per byte for the acknowledge
// - master receiver releases SDA and keeps clocking while slave sends
// - master reader nacks the last byte and then issues a stop
// - slave logic stays active and watches the bus while master runs
// - master detects collisions, loses no message, software may restart
// - master and slave logic each raise their own event requests
// - slave matches seven-bit or ten-bit addresses
// - slave accepts general call, and all addresses in repeater setting
// - slave holds SCL low until reply data has been supplied
// - own rate generator times SCL for 100 kHz and 400 kHz
// - SDA and SCL are only pulled low or released
package i2c_engine_pkg;

  localparam int CLK_MHZ = 250;
  localparam int STD_RATE_KHZ = 100;
  localparam int FAST_RATE_KHZ = 400;
  localparam int PHASES_PER_BIT = 4;
  // quarter-bit counts, rounded down so the bus never runs below rate spec
  localparam int QTR_STD_CYC = (CLK_MHZ * 1000) / (STD_RATE_KHZ * PHASES_PER_BIT);
  localparam int QTR_FAST_CYC = (CLK_MHZ * 1000) / (FAST_RATE_KHZ * PHASES_PER_BIT);
  localparam int QTR_W = 10;

  localparam int BYTE_BITS = 8;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BYTE_DONE = 4'h9;
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;

  typedef enum logic [2:0] {CMD_START, CMD_RESTART, CMD_WRITE, CMD_READ, CMD_STOP} mstCmd_t;
  typedef enum logic [2:0] {M_IDLE, M_START, M_HOLD, M_BIT, M_RESTART, M_STOP} mstState_t;
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ADDR2, S_RX, S_TX, S_WAIT_TX} slvState_t;

endpackage

// [hdl/i2c_line_sync.sv]
// synchroniser and start/stop detector for the SDA and SCL pins
`timescale 1ns/1ps
`default_nettype none
module i2c_line_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sdaIn,
  input wire logic sclIn,
  output logic sdaS,
  output logic sclS,
  output logic sclRise,
  output logic sclFall,
  output logic startSeen,
  output logic stopSeen
);
  import i2c_engine_pkg::*;

  logic [1:0] meta_q, meta_d;
  logic [1:0] sync_q, sync_d;
  logic [1:0] prev_q, prev_d;

  always_comb
  begin
    meta_d = {sdaIn, sclIn};
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // lines idle high, so reset leaves them high to avoid a false start
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
      prev_q <= 2'h3;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign sdaS = sync_q[1];
  assign sclS = sync_q[0];
  assign sclRise = sync_q[0] & ~prev_q[0];
  assign sclFall = ~sync_q[0] & prev_q[0];
  // an SDA edge while SCL stays high is a condition, never data
  assign startSeen = prev_q[0] & sync_q[0] & prev_q[1] & ~sync_q[1];
  assign stopSeen = prev_q[0] & sync_q[0] & ~prev_q[1] & sync_q[1];

endmodule // i2c_line_sync
`default_nettype wire

// [hdl/i2c_bus_engine.sv]
// two-wire bus engine: master and slave logic sharing one pair of pins
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_engine
#(
  parameter int QTR_STD = i2c_engine_pkg::QTR_STD_CYC,
  parameter int QTR_FAST = i2c_engine_pkg::QTR_FAST_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  // pins
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  // master command port
  input wire logic fastMode,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire i2c_engine_pkg::mstCmd_t cmd,
  input wire logic [7:0] cmdData,
  input wire logic cmdNack,
  output logic mstDone,
  output logic mstCollision,
  output logic [7:0] mstRdData,
  output logic mstAckStat,
  output logic masterIrq,
  output logic busBusy,
  // slave configuration and data
  input wire logic [9:0] ownAddr,
  input wire logic addr10Mode,
  input wire logic genCallEn,
  input wire logic repeaterEn,
  output logic slvAddrHit,
  output logic slvGenCall,
  output logic slvReadDir,
  output logic slvRxValid,
  output logic [7:0] slvRxData,
  output logic slvTxReq,
  input wire logic slvTxValid,
  input wire logic [7:0] slvTxData,
  output logic slaveIrq
);
  import i2c_engine_pkg::*;

  if (QTR_STD < 2 || QTR_STD >= (1 << QTR_W) || QTR_FAST < 2 || QTR_FAST > QTR_STD)
  begin : g_bad_rate
    $error("quarter-bit counts out of range");
  end

  localparam logic [QTR_W-1:0] RELOAD_STD = QTR_W'(QTR_STD - 1);
  localparam logic [QTR_W-1:0] RELOAD_FAST = QTR_W'(QTR_FAST - 1);

  logic sdaS, sclS, sclRise, sclFall, startSeen, stopSeen;

  i2c_line_sync u_sync
  (
    .clk(clk),
    .rst(rst),
    .sdaIn(sdaIn),
    .sclIn(sclIn),
    .sdaS(sdaS),
    .sclS(sclS),
    .sclRise(sclRise),
    .sclFall(sclFall),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  // ************************************************************
  // rate generator and bus state
  // ************************************************************
  mstState_t mState_q, mState_d;
  logic [QTR_W-1:0] qCnt_q, qCnt_d;
  logic busy_q, busy_d;
  logic tick;

  assign tick = (qCnt_q == '0);

  always_comb
  begin
    // counter rests while nothing is being timed, so each phase is whole
    if (mState_q == M_IDLE || mState_q == M_HOLD || tick)
      qCnt_d = fastMode ? RELOAD_FAST : RELOAD_STD;
    else
      qCnt_d = qCnt_q - 1'b1;
    busy_d = busy_q;
    if (startSeen)
      busy_d = 1'b1;
    else if (stopSeen)
      busy_d = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      qCnt_q <= '0;
      busy_q <= 1'b0;
    end
    else
    begin
      qCnt_q <= qCnt_d;
      busy_q <= busy_d;
    end
  end

  // ************************************************************
  // master logic
  // ************************************************************
  logic [1:0] mPh_q, mPh_d;
  logic [3:0] mCnt_q, mCnt_d;
  logic [7:0] mSh_q, mSh_d;
  logic mRead_q, mRead_d;
  logic mNack_q, mNack_d;
  logic mSclLow_q, mSclLow_d;
  logic mSdaLow_q, mSdaLow_d;
  logic mDone_q, mDone_d;
  logic mColl_q, mColl_d;
  logic [7:0] mRd_q, mRd_d;
  logic mAck_q, mAck_d;
  logic take;

  assign cmdReady = (mState_q == M_IDLE) || (mState_q == M_HOLD);
  assign take = cmdValid & cmdReady;

  always_comb
  begin
    mState_d = mState_q;
    mPh_d = mPh_q;
    mCnt_d = mCnt_q;
    mSh_d = mSh_q;
    mRead_d = mRead_q;
    mNack_d = mNack_q;
    mSclLow_d = mSclLow_q;
    mSdaLow_d = mSdaLow_q;
    mRd_d = mRd_q;
    mAck_d = mAck_q;
    mDone_d = 1'b0;
    mColl_d = 1'b0;
    case (mState_q)
      M_IDLE:
      begin
        if (take && cmd == CMD_START)
        begin
          // a busy or non-idle bus is refused as a collision
          if (busy_q || !sdaS || !sclS)
            mColl_d = 1'b1;
          else
          begin
            mState_d = M_START;
            mPh_d = 2'd0;
          end
        end
      end
      M_START:
      begin
        if (tick)
        begin
          mPh_d = mPh_q + 2'd1;
          if (mPh_q == 2'd0)
          begin
            if (!sdaS || !sclS)
            begin
              mState_d = M_IDLE;
              mColl_d = 1'b1;
            end
            else
              mSdaLow_d = 1'b1;
          end
          else if (mPh_q == 2'd1)
            mSclLow_d = 1'b1;
          else
          begin
            mState_d = M_HOLD;
            mDone_d = 1'b1;
          end
        end
      end
      M_HOLD:
      begin
        // SCL held low between commands, a wait state on the bus
        if (take)
        begin
          mPh_d = 2'd0;
          mCnt_d = 4'd0;
          case (cmd)
            CMD_WRITE:
            begin
              mState_d = M_BIT;
              mRead_d = 1'b0;
              mSh_d = cmdData;
              mSdaLow_d = ~cmdData[7];
            end
            CMD_READ:
            begin
              mState_d = M_BIT;
              mRead_d = 1'b1;
              mNack_d = cmdNack;
              mSh_d = 8'hFF;
              mSdaLow_d = 1'b0;
            end
            CMD_RESTART:
            begin
              mState_d = M_RESTART;
              mSdaLow_d = 1'b0;
            end
            CMD_STOP:
            begin
              mState_d = M_STOP;
              mSdaLow_d = 1'b1;
            end
            default:
            begin
              mState_d = M_HOLD;
            end
          endcase
        end
      end
      M_BIT:
      begin
        if (tick)
        begin
          case (mPh_q)
            2'd0:
            begin
              mSclLow_d = 1'b0;
              mPh_d = 2'd1;
            end
            2'd1:
            begin
              if (sclS)
                mPh_d = 2'd2;
            end
            2'd2:
            begin
              mPh_d = 2'd3;
              if (mCnt_q < ACK_SLOT)
              begin
                mSh_d = {mSh_q[6:0], sdaS};
                // released a one but the bus shows zero: another master won
                if (!mRead_q && !mSdaLow_q && !sdaS)
                begin
                  mState_d = M_IDLE;
                  mSclLow_d = 1'b0;
                  mSdaLow_d = 1'b0;
                  mColl_d = 1'b1;
                end
              end
              else
                mAck_d = sdaS;
            end
            default:
            begin
              mSclLow_d = 1'b1;
              mPh_d = 2'd0;
              mCnt_d = mCnt_q + 4'd1;
              if (mCnt_q == ACK_SLOT)
              begin
                mState_d = M_HOLD;
                mSdaLow_d = 1'b0;
                mRd_d = mSh_q;
                mDone_d = 1'b1;
              end
              else if (mCnt_q == ACK_SLOT - 4'd1)
                mSdaLow_d = mRead_q & ~mNack_q;
              else
                mSdaLow_d = ~mRead_q & ~mSh_q[7];
            end
          endcase
        end
      end
      M_RESTART, M_STOP:
      begin
        if (tick)
        begin
          case (mPh_q)
            2'd0:
            begin
              mSclLow_d = 1'b0;
              mPh_d = 2'd1;
            end
            2'd1:
            begin
              if (sclS)
              begin
                mPh_d = 2'd2;
                if (mState_q == M_RESTART)
                begin
                  if (!sdaS)
                  begin
                    mState_d = M_IDLE;
                    mColl_d = 1'b1;
                  end
                  else
                    mSdaLow_d = 1'b1;
                end
                else
                  mSdaLow_d = 1'b0;
              end
            end
            2'd2:
            begin
              mPh_d = 2'd3;
              if (mState_q == M_RESTART)
                mSclLow_d = 1'b1;
            end
            default:
            begin
              mDone_d = 1'b1;
              mState_d = (mState_q == M_RESTART) ? M_HOLD : M_IDLE;
              if (mState_q == M_STOP && !sdaS)
              begin
                mDone_d = 1'b0;
                mColl_d = 1'b1;
              end
            end
          endcase
        end
      end
      default:
      begin
        mState_d = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mState_q <= M_IDLE;
      mPh_q <= 2'd0;
      mCnt_q <= 4'd0;
      mSh_q <= 8'h00;
      mRead_q <= 1'b0;
      mNack_q <= 1'b0;
      mSclLow_q <= 1'b0;
      mSdaLow_q <= 1'b0;
      mDone_q <= 1'b0;
      mColl_q <= 1'b0;
      mRd_q <= 8'h00;
      mAck_q <= 1'b0;
    end
    else
    begin
      mState_q <= mState_d;
      mPh_q <= mPh_d;
      mCnt_q <= mCnt_d;
      mSh_q <= mSh_d;
      mRead_q <= mRead_d;
      mNack_q <= mNack_d;
      mSclLow_q <= mSclLow_d;
      mSdaLow_q <= mSdaLow_d;
      mDone_q <= mDone_d;
      mColl_q <= mColl_d;
      mRd_q <= mRd_d;
      mAck_q <= mAck_d;
    end
  end

  // ************************************************************
  // slave logic
  // ************************************************************
  slvState_t sState_q, sState_d;
  logic [3:0] sCnt_q, sCnt_d;
  logic [7:0] sSh_q, sSh_d;
  logic sRead_q, sRead_d;
  logic sTen_q, sTen_d;
  logic sHi_q, sHi_d;
  logic sNack_q, sNack_d;
  logic sSclLow_q, sSclLow_d;
  logic sSdaLow_q, sSdaLow_d;
  logic sHit_q, sHit_d;
  logic sGc_q, sGc_d;
  logic sRxV_q, sRxV_d;
  logic [7:0] sRx_q, sRx_d;
  logic m7, m10, gc;

  // the slave always watches the bus, including our own master's traffic
  always_comb
  begin
    m7 = !addr10Mode && (sSh_q[7:1] == ownAddr[6:0]);
    m10 = addr10Mode && (sSh_q[7:3] == TEN_BIT_PREFIX) && (sSh_q[2:1] == ownAddr[9:8]);
    gc = genCallEn && (sSh_q == GEN_CALL_ADDR);
    sState_d = sState_q;
    sCnt_d = sCnt_q;
    sSh_d = sSh_q;
    sRead_d = sRead_q;
    sTen_d = sTen_q;
    sHi_d = sHi_q;
    sNack_d = sNack_q;
    sSclLow_d = sSclLow_q;
    sSdaLow_d = sSdaLow_q;
    sGc_d = sGc_q;
    sRx_d = sRx_q;
    sHit_d = 1'b0;
    sRxV_d = 1'b0;
    if (stopSeen)
    begin
      sState_d = S_IDLE;
      sSclLow_d = 1'b0;
      sSdaLow_d = 1'b0;
      sHi_d = 1'b0;
    end
    else if (startSeen)
    begin
      sState_d = S_ADDR;
      sCnt_d = 4'd0;
      sSdaLow_d = 1'b0;
      sSclLow_d = 1'b0;
    end
    else if (sState_q == S_WAIT_TX)
    begin
      if (slvTxValid)
      begin
        sSh_d = slvTxData;
        sSdaLow_d = ~slvTxData[7];
        sState_d = S_TX;
      end
    end
    else if (sState_q == S_TX && sSclLow_q)
      sSclLow_d = 1'b0; // data settled one cycle before the clock is freed
    else if (sState_q != S_IDLE && sclRise)
    begin
      sCnt_d = sCnt_q + 4'd1;
      if (sCnt_q < ACK_SLOT && sState_q != S_TX)
        sSh_d = {sSh_q[6:0], sdaS};
      else if (sCnt_q == ACK_SLOT && sState_q == S_TX)
        sNack_d = sdaS;
    end
    else if (sState_q != S_IDLE && sclFall)
    begin
      if (sCnt_q < ACK_SLOT && sState_q == S_TX)
      begin
        sSh_d = {sSh_q[6:0], 1'b1};
        sSdaLow_d = ~sSh_q[6];
      end
      else if (sCnt_q == ACK_SLOT)
      begin
        case (sState_q)
          S_ADDR:
          begin
            sGc_d = gc;
            sTen_d = 1'b0;
            sRead_d = sSh_q[0];
            if (sSh_q[0] && (m7 || (m10 && sHi_q) || repeaterEn))
              sSdaLow_d = 1'b1;
            else if (!sSh_q[0] && (m7 || gc || repeaterEn))
              sSdaLow_d = 1'b1;
            else if (!sSh_q[0] && m10)
            begin
              sSdaLow_d = 1'b1;
              sTen_d = 1'b1;
            end
            else
              sState_d = S_IDLE;
            sHit_d = (sSh_q[0] && (m7 || (m10 && sHi_q) || repeaterEn)) ||
                     (!sSh_q[0] && (m7 || gc || repeaterEn));
          end
          S_ADDR2:
          begin
            if (sSh_q == ownAddr[7:0])
            begin
              sSdaLow_d = 1'b1;
              sHi_d = 1'b1;
              sTen_d = 1'b0;
              sHit_d = 1'b1;
            end
            else
              sState_d = S_IDLE;
          end
          S_RX:
          begin
            sSdaLow_d = 1'b1;
            sRx_d = sSh_q;
            sRxV_d = 1'b1;
          end
          default:
          begin
            sSdaLow_d = 1'b0;
          end
        endcase
      end
      else if (sCnt_q == BYTE_DONE)
      begin
        sCnt_d = 4'd0;
        sSdaLow_d = 1'b0;
        if (sState_q == S_ADDR && sTen_q)
          sState_d = S_ADDR2;
        else if ((sState_q == S_TX && !sNack_q) || (sState_q != S_TX && sRead_q))
        begin
          sState_d = S_WAIT_TX;
          sSclLow_d = 1'b1;
        end
        else if (sState_q == S_TX)
          sState_d = S_IDLE;
        else
          sState_d = S_RX;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sState_q <= S_IDLE;
      sCnt_q <= 4'd0;
      sSh_q <= 8'h00;
      sRead_q <= 1'b0;
      sTen_q <= 1'b0;
      sHi_q <= 1'b0;
      sNack_q <= 1'b0;
      sSclLow_q <= 1'b0;
      sSdaLow_q <= 1'b0;
      sHit_q <= 1'b0;
      sGc_q <= 1'b0;
      sRxV_q <= 1'b0;
      sRx_q <= 8'h00;
    end
    else
    begin
      sState_q <= sState_d;
      sCnt_q <= sCnt_d;
      sSh_q <= sSh_d;
      sRead_q <= sRead_d;
      sTen_q <= sTen_d;
      sHi_q <= sHi_d;
      sNack_q <= sNack_d;
      sSclLow_q <= sSclLow_d;
      sSdaLow_q <= sSdaLow_d;
      sHit_q <= sHit_d;
      sGc_q <= sGc_d;
      sRxV_q <= sRxV_d;
      sRx_q <= sRx_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // open drain: only ever pull low, the pull-ups make the high level
  assign sdaOut = 1'b0;
  assign sclOut = 1'b0;
  assign sdaOe = mSdaLow_q | sSdaLow_q;
  assign sclOe = mSclLow_q | sSclLow_q;
  assign mstDone = mDone_q;
  assign mstCollision = mColl_q;
  assign mstRdData = mRd_q;
  assign mstAckStat = mAck_q;
  assign masterIrq = mDone_q | mColl_q;
  assign busBusy = busy_q;
  assign slvAddrHit = sHit_q;
  assign slvGenCall = sGc_q;
  assign slvReadDir = sRead_q;
  assign slvRxValid = sRxV_q;
  assign slvRxData = sRx_q;
  assign slvTxReq = (sState_q == S_WAIT_TX);
  assign slaveIrq = sHit_q | sRxV_q | slvTxReq;

endmodule // i2c_bus_engine
`default_nettype wire

// [bench/i2c_far_slave.sv]
// behavioural far-side slave peripheral on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module i2c_far_slave
#(
  parameter logic [6:0] DEV_ADDR = 7'h5A,
  parameter logic [7:0] REPLY = 8'hC3
)
(
  input wire logic sda,
  input wire logic scl,
  input wire logic stretch,
  output logic sdaPull,
  output logic sclPull,
  output logic [7:0] lastRx
);
  int bitNo = 0;
  logic [7:0] sh = 8'h00;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic addrPh = 1'b0;
  // only ever pulls low; the bench pull-up gives the released level
  initial sdaPull = 1'b0;
  initial sclPull = 1'b0;
  initial lastRx = 8'h00;
  always @(negedge sda)
    if (scl)
    begin
      bitNo = -1;
      addrPh = 1'b1;
      sel = 1'b0;
      sdaPull = 1'b0;
    end
  always @(posedge sda)
    if (scl)
      sel = 1'b0;
  always @(posedge scl)
    if (bitNo < 8)
      sh = {sh[6:0], sda};
    else if (rd && sda)
      sel = 1'b0;
  // data only moves while the clock is low
  always @(negedge scl)
  begin
    bitNo = bitNo + 1;
    if (bitNo == 9)
    begin
      bitNo = 0;
      sdaPull = 1'b0;
    end
    if (bitNo == 8 && addrPh)
    begin
      sel = (sh[7:1] == DEV_ADDR);
      rd = sh[0];
      addrPh = 1'b0;
      sdaPull = sel;
    end
    else if (bitNo == 8)
    begin
      if (sel && !rd)
        lastRx = sh;
      sdaPull = sel && !rd;
    end
    else if (sel && rd)
      sdaPull = ~REPLY[7 - bitNo];
    if (stretch && sel)
    begin
      sclPull = 1'b1;
      #200;
      sclPull = 1'b0;
    end
  end
endmodule // i2c_far_slave
`default_nettype wire

// [bench/i2c_bus_engine_chk.sv]
// assertions on the ports of the two-wire bus engine
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_engine_chk
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire i2c_engine_pkg::mstCmd_t cmd,
  input wire logic mstDone,
  input wire logic mstCollision,
  input wire logic masterIrq,
  input wire logic busBusy,
  input wire logic slvAddrHit,
  input wire logic slvRxValid,
  input wire logic slvTxReq,
  input wire logic slvTxValid,
  input wire logic slaveIrq
);
  import i2c_engine_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ****
  // assertions
  // ****
  a_open_drain: assert property (sdaOut == 1'b0 && sclOut == 1'b0)
    else $error("pin driven high");
  a_master_irq: assert property (masterIrq == (mstDone | mstCollision))
    else $error("master event request wrong");
  a_slave_irq: assert property (slaveIrq == (slvAddrHit | slvRxValid | slvTxReq))
    else $error("slave event request wrong");
  a_start_refused: assert property (cmdValid && cmdReady && cmd == CMD_START && busBusy
    |=> mstCollision) else $error("start on busy bus not refused");
  a_stretch_hold: assert property (slvTxReq |-> sclOe)
    else $error("clock not held while reply missing");
  a_stretch_release: assert property (slvTxReq && slvTxValid |=> !slvTxReq)
    else $error("clock not released after reply");
  a_collision_quit: assert property (mstCollision |=> !sclOe && cmdReady)
    else $error("master kept bus after collision");
  a_done_pulse: assert property (mstDone |-> cmdReady ##1 !mstDone)
    else $error("done not a single pulse in ready state");
  a_idle_quiet: assert property (cmdReady && !busBusy && !mstCollision |-> !sclOe)
    else $error("clock pulled on idle bus");
  c_collision: cover property (mstCollision);
  c_addr_hit: cover property (slvAddrHit);
  c_stretch: cover property (slvTxReq && slvTxValid);
endmodule // i2c_bus_engine_chk
bind i2c_bus_engine i2c_bus_engine_chk i2c_bus_engine_chk_inst (.clk(clk), .rst(rst),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .sclOut(sclOut), .sclOe(sclOe), .cmdValid(cmdValid),
  .cmdReady(cmdReady), .cmd(cmd), .mstDone(mstDone), .mstCollision(mstCollision),
  .masterIrq(masterIrq), .busBusy(busBusy), .slvAddrHit(slvAddrHit), .slvRxValid(slvRxValid),
  .slvTxReq(slvTxReq), .slvTxValid(slvTxValid), .slaveIrq(slaveIrq));
`default_nettype wire

// [bench/i2c_bus_engine_test.sv]
// self-checking bench for the two-wire bus engine
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_engine_test;
  import i2c_engine_pkg::*;
  localparam logic [6:0] FAR_ADDR = 7'h5A;
  logic clk, rst = 1'b1, fastMode = 1'b0, cmdValid = 1'b0, cmdNack = 1'b0;
  logic tbSda = 1'b1, tbScl = 1'b1, stretch = 1'b0, genCallEn = 1'b1, repeaterEn = 1'b0;
  logic slvTxValid = 1'b0, addr10Mode = 1'b0;
  mstCmd_t cmd = CMD_START;
  logic [7:0] cmdData = 8'h00, lastRx, mstRdData, slvRxData, rxByte = 8'h00;
  logic [9:0] ownAddr = 10'h02C;
  logic sdaOe, sclOe, farSda, farScl, cmdReady, mstDone, mstCollision, mstAckStat, busBusy;
  logic slvAddrHit, slvTxReq, slvRxValid, slvGenCall, slvReadDir;
  int failures = 0, checked = 0, hits = 0;
  // wired-and with pull-ups: released lines read high
  wire sda = tbSda & ~sdaOe & ~farSda;
  wire scl = tbScl & ~sclOe & ~farScl;
  i2c_bus_engine #(.QTR_STD(8), .QTR_FAST(4)) i2c_bus_engine_inst (.clk(clk), .rst(rst),
    .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe), .sclIn(scl), .sclOut(), .sclOe(sclOe),
    .fastMode(fastMode), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmd(cmd),
    .cmdData(cmdData), .cmdNack(cmdNack), .mstDone(mstDone), .mstCollision(mstCollision),
    .mstRdData(mstRdData), .mstAckStat(mstAckStat), .masterIrq(), .busBusy(busBusy),
    .ownAddr(ownAddr), .addr10Mode(addr10Mode), .genCallEn(genCallEn),
    .repeaterEn(repeaterEn), .slvAddrHit(slvAddrHit), .slvGenCall(slvGenCall),
    .slvReadDir(slvReadDir), .slvRxValid(slvRxValid), .slvRxData(slvRxData),
    .slvTxReq(slvTxReq), .slvTxValid(slvTxValid), .slvTxData(8'hA5), .slaveIrq());
  i2c_far_slave #(.DEV_ADDR(FAR_ADDR), .REPLY(8'hC3)) i2c_far_slave_inst (.sda(sda),
    .scl(scl), .stretch(stretch), .sdaPull(farSda), .sclPull(farScl), .lastRx(lastRx));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // reply comes a cycle late so the stretch is seen
  always @(posedge clk)
  begin
    if (slvAddrHit)
      hits++;
    if (slvRxValid)
      rxByte <= slvRxData;
    slvTxValid <= #1 slvTxReq;
  end
  // ****
  // shared tasks
  // ****
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic mcmd(input mstCmd_t c, input logic [7:0] d, input logic nk);
    int n;
    cmd = c;
    cmdData = d;
    cmdNack = nk;
    cmdValid = 1'b1;
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    n = 0;
    while (mstDone !== 1'b1 && mstCollision !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("master answer", 8'(n < 4000), 8'h01);
  endtask
  // second master on the wire, one bit per 80 ns clock
  task automatic tbBit(input logic b, output logic r);
    int n;
    tbSda = b;
    #20;
    tbScl = 1'b1;
    n = 0;
    while (scl !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    #20;
    r = sda;
    #20;
    tbScl = 1'b0;
    #20;
  endtask
  task automatic tbByte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--)
      tbBit(d[i], q[i]);
    tbBit(1'b1, ack);
  endtask
  task automatic tbStart();
    #40;
    tbSda = 1'b0;
    #20;
    tbScl = 1'b0;
    #20;
  endtask
  task automatic tbStop();
    tbSda = 1'b0;
    #20;
    tbScl = 1'b1;
    #20;
    tbSda = 1'b1;
    #40;
  endtask
  // ****
  // scenarios
  // ****
  task automatic tWrite();
    mcmd(CMD_START, 8'h00, 1'b0);
    chk("busy after start", 8'(busBusy), 8'h01);
    mcmd(CMD_WRITE, {FAR_ADDR, 1'b0}, 1'b0);
    chk("address ack", 8'(mstAckStat), 8'h00);
    mcmd(CMD_WRITE, 8'h96, 1'b0);
    chk("far byte", lastRx, 8'h96);
    chk("data ack", 8'(mstAckStat), 8'h00);
    mcmd(CMD_STOP, 8'h00, 1'b0);
    repeat (4) @(posedge clk);
    chk("busy after stop", 8'(busBusy), 8'h00);
    chk("idle lines", {6'h00, sda, scl}, 8'h03);
  endtask
  task automatic tRead();
    fastMode = 1'b1;
    stretch = 1'b1;
    mcmd(CMD_START, 8'h00, 1'b0);
    mcmd(CMD_WRITE, 8'h22, 1'b0);
    chk("absent slave nack", 8'(mstAckStat), 8'h01);
    mcmd(CMD_RESTART, 8'h00, 1'b0);
    mcmd(CMD_WRITE, {FAR_ADDR, 1'b1}, 1'b0);
    chk("read address ack", 8'(mstAckStat), 8'h00);
    mcmd(CMD_READ, 8'h00, 1'b1);
    chk("read byte", mstRdData, 8'hC3);
    mcmd(CMD_STOP, 8'h00, 1'b0);
    repeat (4) @(posedge clk);
    chk("idle after read", 8'(busBusy), 8'h00);
    fastMode = 1'b0;
    stretch = 1'b0;
  endtask
  task automatic tCollide();
    mcmd(CMD_START, 8'h00, 1'b0);
    tbSda = 1'b0;
    mcmd(CMD_WRITE, 8'hFF, 1'b0);
    chk("collision", 8'(mstCollision), 8'h01);
    #20;
    tbSda = 1'b1;
    #40;
    chk("free after collision", {6'h00, sda, scl}, 8'h03);
  endtask
  task automatic tSlave();
    logic [7:0] q;
    logic ack;
    logic [7:0] addrs [4] = '{8'h58, 8'h00, 8'h66, 8'hF0};
    for (int i = 0; i < 4; i++)
    begin
      repeaterEn = (i == 2);
      addr10Mode = (i == 3);
      hits = 0;
      tbStart();
      if (i == 0)
      begin
        mcmd(CMD_START, 8'h00, 1'b0);
        chk("start refused", 8'(mstCollision), 8'h01);
      end
      tbByte(addrs[i], q, ack);
      if (i == 3)
        tbByte(8'h2C, q, ack);
      chk("slave ack", 8'(ack), 8'h00);
      chk("address hit", 8'(hits), 8'h01);
      chk("general call", 8'(slvGenCall), 8'(i == 1));
      tbByte(8'h3C + 8'(i), q, ack);
      chk("slave rx", rxByte, 8'h3C + 8'(i));
      tbStop();
    end
    addr10Mode = 1'b0;
    tbStart();
    tbByte(8'h59, q, ack);
    chk("read direction", 8'(slvReadDir), 8'h01);
    tbByte(8'hFF, q, ack);
    chk("slave reply", q, 8'hA5);
    tbStop();
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("pulls after reset", {6'h00, sdaOe, sclOe}, 8'h00);
    chk("ready after reset", 8'(cmdReady), 8'h01);
    tWrite();
    tRead();
    tCollide();
    tWrite();
    tSlave();
    complete_run();
  end
  // ten times the expected 20 us marks a hang
  initial
  begin
    #200000;
    failures++;
    complete_run();
  end
endmodule // i2c_bus_engine_test
`default_nettype wire
